//--- sim/timer16_capture_compare_core_test.sv
// Purpose: Self-checking bench of the timer core.
// Assumes: Inputs change 1 ns after mclk rises.
// Notes: Counter written only while stopped; the first tick after a write still skips the compare match.
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare_core_test;
  import tmr_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  tmr_io_req_t io_req;
  logic [7:0] io_rdata, d;
  logic [1:0] wave_mode_low = 2'b00;
  logic capture_pin = 1'b0;
  logic external_count_pin = 1'b0;
  tmr_flags_t flag_vector_ack = '0;
  tmr_flags_t flag_write_clear = '0;
  tmr_flags_t flags;
  logic [15:0] capture_register, counter_value;
  logic compare_a_match, compare_b_match;
  int errors = 0;
  int check_count = 0;
  int n, c1, c2;
  int dv[6] = '{1, 1, 8, 64, 256, 1024};
  always #5 mclk = ~mclk;
  tmr_top dut (.mclk(mclk), .srst(srst), .io_req(io_req),
    .io_rdata(io_rdata), .wave_mode_low(wave_mode_low),
    .capture_pin(capture_pin), .external_count_pin(external_count_pin),
    .flag_vector_ack(flag_vector_ack), .flag_write_clear(flag_write_clear),
    .flags(flags), .capture_register(capture_register),
    .counter_value(counter_value), .compare_a_match(compare_a_match),
    .compare_b_match(compare_b_match));
  tmr_cpu_model cpu (.mclk(mclk), .io_rdata(io_rdata), .io_req(io_req));
  // ----
  // Checking and ending
  // ----
  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input logic [15:0] g, lo, hi);
    check_count++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    cpu.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  // ----
  // Stimulus helpers
  // ----
  // Written while stopped: a running write may miss a match
  task automatic setcnt(input logic [15:0] v);
    cpu.wr(OFS_COUNTER_HIGH, v[15:8]);
    cpu.wr(OFS_COUNTER_LOW, v[7:0]);
  endtask
  task automatic wait_flag(input int b);
    int k;
    k = 0;
    while (flags[b] !== 1'b1) begin
      @(posedge mclk);
      #1 k++;
      if (k > 100) begin
        errors++;
        report_and_stop();
      end
    end
  endtask
  task automatic ext(input logic [7:0] cs);
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h00);
    setcnt(16'h0000);
    cpu.wr(OFS_TIMER_CONTROL_B, cs);
    repeat (5) begin
      repeat (4) @(posedge mclk);
      #1 external_count_pin = ~external_count_pin;
    end
    repeat (6) @(posedge mclk);
    #1 chk(counter_value, 16'h0003);
  endtask
  // Toggles the pin, optionally back after h cycles; n=16 if no capture
  task automatic cap(input logic [7:0] cr, input int h, output int n);
    cpu.wr(OFS_TIMER_CONTROL_B, cr);
    capture_pin = ~capture_pin;
    if (h > 0) begin
      repeat (h) @(posedge mclk);
      #1 capture_pin = ~capture_pin;
    end
    n = 0;
    while (flags.capture !== 1'b1 && n < 16) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n < 16) begin
      chk(capture_register, counter_value - 16'h0001);
      flag_vector_ack.capture = 1'b1;
      @(posedge mclk);
      #1 flag_vector_ack.capture = 1'b0;
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (12) @(posedge mclk);
    #1 srst = 1'b0;
    @(posedge mclk);
    #1;
    for (int a = 'h28; a <= 'h30; a++) begin
      rd_chk(6'(a), 8'h00);
    end
    cpu.wr(OFS_TIMER_CONTROL_B, 8'hff);
    rd_chk(OFS_TIMER_CONTROL_B, 8'hdf);
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h00);
    cpu.wr(OFS_COMPARE_A_HIGH, 8'h12);
    cpu.wr(OFS_COMPARE_A_LOW, 8'h34);
    rd_chk(OFS_COMPARE_A_LOW, 8'h34);
    rd_chk(OFS_COMPARE_A_HIGH, 8'h12);
    setcnt(16'habcd);
    chk(counter_value, 16'habcd);
    rd_chk(OFS_COUNTER_LOW, 8'hcd);
    rd_chk(OFS_COUNTER_HIGH, 8'hab);
    cpu.wr(OFS_COUNTER_HIGH, 8'h56);
    cpu.wr(OFS_COMPARE_A_LOW, 8'h10);
    rd_chk(OFS_COMPARE_A_HIGH, 8'h56);
    cpu.wr(OFS_COMPARE_A_HIGH, 8'h00);
    cpu.wr(OFS_COMPARE_A_LOW, 8'h10);
    cpu.wr(OFS_COMPARE_B_HIGH, 8'h00);
    cpu.wr(OFS_COMPARE_B_LOW, 8'h05);
    setcnt(16'h0000);
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h01);
    wait_flag(0);
    chk(counter_value, 16'h0006);
    chk({15'h0, compare_b_match}, 16'h0001);
    wait_flag(1);
    chk(counter_value, 16'h0011);
    chk({15'h0, compare_a_match}, 16'h0001);
    flag_write_clear.compare_a = 1'b1;
    flag_vector_ack.compare_b = 1'b1;
    @(posedge mclk);
    #1 flag_write_clear = '0;
    flag_vector_ack = '0;
    chk({14'h0, flags[1:0]}, 16'h0000);
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h00);
    setcnt(16'h0010);
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h01);
    repeat (4) @(posedge mclk);
    #1 chk({15'h0, flags.compare_a}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      cpu.wr(OFS_TIMER_CONTROL_B, 8'h00);
      setcnt(16'h0000);
      cpu.wr(OFS_TIMER_CONTROL_B, 8'(i));
      repeat (2048) @(posedge mclk);
      #1 cpu.wr(OFS_TIMER_CONTROL_B, 8'h00);
      n = (i == 0) ? 0 : 2048 / dv[i];
      chk_rng(counter_value, 16'(n - (i > 1)),
        16'(n + ((i == 1) ? 3 : (i > 1))));
    end
    ext(8'h07);
    ext(8'h06);
    setcnt(16'h0000);
    cap(8'h41, 0, c1);
    chk_rng(16'(c1), 16'h0000, 16'h000f);
    cap(8'h41, 0, n);
    chk(16'(n), 16'h0010);
    cap(8'h01, 0, n);
    chk(16'(n), 16'h0010);
    cap(8'h01, 0, c2);
    chk(16'(c2), 16'(c1));
    cap(8'hc1, 0, c2);
    chk(16'(c2), 16'(c1 + 4));
    cap(8'h81, 2, n);
    chk(16'(n), 16'h0010);
    cap(8'h19, 0, n);
    chk(16'(n), 16'h0010);
    // Fixed 8-bit top: single slope wraps, dual slope turns back
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h00);
    wave_mode_low = 2'b01;
    setcnt(16'h00fe);
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h09);
    chk(counter_value, 16'h00ff);
    @(posedge mclk);
    #1 chk(counter_value, 16'h0000);
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h00);
    setcnt(16'h00fe);
    cpu.wr(OFS_TIMER_CONTROL_B, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk(counter_value, 16'h00fd);
    report_and_stop();
  end
endmodule // timer16_capture_compare_core_test
`default_nettype wire

//--- sim/tmr_cpu_model.sv
// Purpose: CPU side of the timer's I/O register bus.
// Assumes: Calls start 1 ns after a rising mclk.
// Notes: Each access takes two cycles; idle bus shows inverted values.
`timescale 1ns/1ps
`default_nettype none
module tmr_cpu_model (
  input wire logic mclk,
  input wire logic [7:0] io_rdata,
  output tmr_pkg::tmr_io_req_t io_req
);
  import tmr_pkg::*;
  initial io_req = '0;
  // I/O offsets only; data space base is added elsewhere
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    io_req <= {2'b10, a, v};
    @(posedge mclk);
    #1 io_req <= {2'b00, ~a, ~v};
    @(posedge mclk);
    #1;
  endtask
  // Low read first so the high byte comes from the temp
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    io_req <= {2'b01, a, 8'h00};
    @(posedge mclk);
    #1 io_req <= {2'b00, ~a, 8'hff};
    v = io_rdata;
    @(posedge mclk);
    #1;
  endtask
endmodule // tmr_cpu_model
`default_nettype wire

//--- sim/tmr_top_sva.sv
// Purpose: Port-level checks of the timer core.
// Assumes: One clock domain, synchronous reset.
// Notes: Bound into every tmr_top instance.
`timescale 1ns/1ps
`default_nettype none
module tmr_top_sva (
  input wire logic mclk,
  input wire logic srst,
  input wire tmr_pkg::tmr_io_req_t io_req,
  input wire logic [7:0] io_rdata,
  input wire tmr_pkg::tmr_flags_t flag_vector_ack,
  input wire tmr_pkg::tmr_flags_t flag_write_clear,
  input wire tmr_pkg::tmr_flags_t flags,
  input wire logic [15:0] capture_register,
  input wire logic [15:0] counter_value,
  input wire logic compare_a_match,
  input wire logic compare_b_match
);
  import tmr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_lo_wr;
    io_req.wr && io_req.addr == OFS_COUNTER_LOW;
  endsequence
  property p_reset_zero;
    $fell(srst) |-> counter_value == 16'h0000 && flags == 3'h0;
  endproperty
  property p_match_a;
    compare_a_match |-> flags.compare_a;
  endproperty
  // A clear in the pulse cycle may legally drop the flag one edge later
  property p_match_b;
    $rose(compare_b_match) |=> !compare_b_match && (flags.compare_b ||
      $past(flag_vector_ack.compare_b) || $past(flag_write_clear.compare_b));
  endproperty
  property p_cnt_low;
    s_lo_wr |=> counter_value[7:0] == $past(io_req.wdata);
  endproperty
  property p_cnt_pair;
    (io_req.wr && io_req.addr == OFS_COUNTER_HIGH)
      ##1 (!io_req.wr && !io_req.rd) ##1 s_lo_wr
      |=> counter_value[15:8] == $past(io_req.wdata, 3);
  endproperty
  property p_rd_unmapped;
    io_req.rd && (io_req.addr < OFS_COMPARE_B_LOW ||
      io_req.addr > OFS_TIMER_CONTROL_B) |=> io_rdata == 8'h00;
  endproperty
  property p_rdata_hold;
    !io_req.rd |=> $stable(io_rdata);
  endproperty
  property p_cap_value;
    $rose(flags.capture) |-> capture_register == $past(counter_value);
  endproperty
  property p_cap_hold;
    flags.capture && !flag_vector_ack.capture && !flag_write_clear.capture
      |=> flags.capture;
  endproperty
  property p_flag_clear;
    flag_write_clear.compare_a |=> flags.compare_a == compare_a_match;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("counter or flags not zero after reset");
  a_match_a: assert property (p_match_a)
    else $error("compare A pulse without flag");
  a_match_b: assert property (p_match_b)
    else $error("compare B pulse wrong");
  a_cnt_low: assert property (p_cnt_low)
    else $error("counter low byte not written");
  a_cnt_pair: assert property (p_cnt_pair)
    else $error("counter high byte not taken from temp");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without read");
  a_cap_value: assert property (p_cap_value)
    else $error("capture value wrong");
  a_cap_hold: assert property (p_cap_hold)
    else $error("capture flag lost");
  a_flag_clear: assert property (p_flag_clear)
    else $error("compare A flag not cleared");
endmodule // tmr_top_sva
bind tmr_top tmr_top_sva u_sva (.mclk(mclk), .srst(srst), .io_req(io_req),
  .io_rdata(io_rdata), .flag_vector_ack(flag_vector_ack),
  .flag_write_clear(flag_write_clear), .flags(flags),
  .capture_register(capture_register), .counter_value(counter_value),
  .compare_a_match(compare_a_match), .compare_b_match(compare_b_match));
`default_nettype wire

//--- src/tmr_capfilt.sv
// Purpose: Capture pin noise filter.
// Assumes: Input already synchronised to mclk.
// Notes: Bypass path is combinational so the filter adds exactly four.
`timescale 1ns/1ps
`default_nettype none
module tmr_capfilt
  import tmr_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic enable,
  input wire logic level_in,
  output logic level_out
);

  logic level_q, level_d;
  logic [2:0] cnt_q, cnt_d;

  always_comb begin
    level_d = level_q;
    cnt_d = 3'h0;
    if (!enable) begin
      // Track input so enabling the filter gives no false edge
      level_d = level_in;
    end else if (level_in != level_q) begin
      if (cnt_q == 3'(FILTER_SAMPLES - 1)) begin
        level_d = level_in;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      level_q <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

  assign level_out = enable ? level_q : level_in;

endmodule // tmr_capfilt
`default_nettype wire

//--- src/tmr_pkg.sv
// Purpose: Shared constants and types for the 16-bit timer core.
// Assumes: 6-bit I/O address, 8-bit data, 100 MHz mclk.
// Notes: Offsets are I/O addresses; data space adds the I/O base.
package tmr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_COMPARE_B_LOW = 6'h28;
  localparam logic [5:0] OFS_COMPARE_B_HIGH = 6'h29;
  localparam logic [5:0] OFS_COMPARE_A_LOW = 6'h2a;
  localparam logic [5:0] OFS_COMPARE_A_HIGH = 6'h2b;
  localparam logic [5:0] OFS_COUNTER_LOW = 6'h2c;
  localparam logic [5:0] OFS_COUNTER_HIGH = 6'h2d;
  localparam logic [5:0] OFS_TIMER_CONTROL_B = 6'h2e;

  // ----------------------------------------------------------------
  // Control B fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_FILTER_EN = 7;
  localparam int BIT_EDGE_SEL = 6;
  localparam int BIT_WAVE3 = 4;
  localparam int BIT_WAVE2 = 3;
  localparam int CS_MSB = 2;
  localparam logic [7:0] CTRL_B_RW_MASK = 8'hdf;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Clock select codes and prescaler widths (log2 of divide)
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PS_LOG_8 = 3;
  localparam int PS_LOG_64 = 6;
  localparam int PS_LOG_256 = 8;
  localparam int PS_LOG_1024 = 10;

  // ----------------------------------------------------------------
  // Capture filter and count limits
  // ----------------------------------------------------------------
  localparam int FILTER_SAMPLES = 4;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TOP_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    TMR_DIR_UP = 1'b0,
    TMR_DIR_DOWN = 1'b1
  } tmr_dir_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tmr_io_req_t;

  typedef struct packed {
    logic capture;
    logic compare_a;
    logic compare_b;
  } tmr_flags_t;

endpackage

//--- src/tmr_presc.sv
// Purpose: Timer clock source select and prescaler.
// Assumes: External edges already synchronised and detected.
// Notes: Prescaler runs free, so the first divided tick may come early.
`timescale 1ns/1ps
`default_nettype none
module tmr_presc
  import tmr_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [2:0] clock_select_field,
  input wire logic ext_fall,
  input wire logic ext_rise,
  output logic tick
);

  logic [PS_LOG_1024-1:0] ps_q, ps_d;

  function automatic logic ones(input logic [PS_LOG_1024-1:0] v,
                                input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < PS_LOG_1024; i++) begin
      if (i < n) r = r & v[i];
    end
    return r;
  endfunction

  always_comb begin
    ps_d = ps_q + 1'b1;
    unique case (clock_select_field)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = ones(ps_q, PS_LOG_8);
      CS_DIV64: tick = ones(ps_q, PS_LOG_64);
      CS_DIV256: tick = ones(ps_q, PS_LOG_256);
      CS_DIV1024: tick = ones(ps_q, PS_LOG_1024);
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ps_q <= '0;
    end else begin
      ps_q <= ps_d;
    end
  end

endmodule // tmr_presc
`default_nettype wire

//--- src/tmr_top.sv
// Purpose: 16-bit timer core with capture and two compare units.
// Assumes: CPU I/O register bus on mclk; pins asynchronous.
// Notes: 16-bit writes and counter reads pass through one shared high-byte holding register.
`timescale 1ns/1ps
`default_nettype none

module tmr_top
  import tmr_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire tmr_pkg::tmr_io_req_t io_req,
  output logic [7:0] io_rdata,
  input wire logic [1:0] wave_mode_low,
  input wire logic capture_pin,
  input wire logic external_count_pin,
  input wire tmr_pkg::tmr_flags_t flag_vector_ack,
  input wire tmr_pkg::tmr_flags_t flag_write_clear,
  output tmr_pkg::tmr_flags_t flags,
  output logic [15:0] capture_register,
  output logic [15:0] counter_value,
  output logic compare_a_match,
  output logic compare_b_match
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic cap_s1_q, cap_s2_q, ext_s1_q, ext_s2_q, ext_prev_q;

  // pin sampled regardless of its port direction
  always_ff @(posedge mclk) begin
    if (srst) begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      cap_s1_q <= capture_pin;
      cap_s2_q <= cap_s1_q;
      ext_s1_q <= external_count_pin;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_b_q, ctrl_b_d;
  logic [7:0] temp_q, temp_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] ocra_q, ocra_d;
  logic [15:0] ocrb_q, ocrb_d;
  logic [15:0] icr_q, icr_d;
  logic [7:0] rdata_q, rdata_d;
  logic block_q, block_d;
  logic cap_prev_q, cap_prev_d;
  logic match_a_q, match_a_d, match_b_q, match_b_d;
  tmr_dir_t dir_q, dir_d;
  tmr_flags_t flags_q, flags_d;

  logic [3:0] wave_mode_field;
  logic [15:0] top;
  logic tick, cap_level, cap_edge, cnt_wr, cap_active;
  logic hit_a, hit_b;

  assign wave_mode_field = {ctrl_b_q[BIT_WAVE3], ctrl_b_q[BIT_WAVE2],
                            wave_mode_low};

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  function automatic logic icr_is_top(input logic [3:0] m);
    return (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
  endfunction

  function automatic logic dual_slope(input logic [3:0] m);
    return (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
  endfunction

  // count limit per mode; reserved code acts as normal
  function automatic logic [15:0] top_of(input logic [3:0] m,
                                         input logic [15:0] icr,
                                         input logic [15:0] ocra);
    logic [15:0] t;
    t = TOP_MAX;
    case (m)
      4'h1, 4'h5: t = TOP_8BIT;
      4'h2, 4'h6: t = TOP_9BIT;
      4'h3, 4'h7: t = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: t = ocra;
      4'h8, 4'ha, 4'hc, 4'he: t = icr;
      default: t = TOP_MAX;
    endcase
    return t;
  endfunction

  assign top = top_of(wave_mode_field, icr_q, ocra_q);
  assign cap_active = !icr_is_top(wave_mode_field);

  // ----------------------------------------------------------------
  // Clock source and capture filter
  // ----------------------------------------------------------------
  tmr_presc u_presc (
    .mclk(mclk),
    .srst(srst),
    .clock_select_field(ctrl_b_q[CS_MSB:0]),
    .ext_fall(ext_prev_q && !ext_s2_q),
    .ext_rise(!ext_prev_q && ext_s2_q),
    .tick(tick)
  );

  tmr_capfilt u_capfilt (
    .mclk(mclk),
    .srst(srst),
    .enable(ctrl_b_q[BIT_FILTER_EN]),
    .level_in(cap_s2_q),
    .level_out(cap_level)
  );

  // edge polarity from the edge select bit
  assign cap_edge = ctrl_b_q[BIT_EDGE_SEL] ? (cap_level && !cap_prev_q)
                                          : (!cap_level && cap_prev_q);

  assign cnt_wr = io_req.wr && (io_req.addr == OFS_COUNTER_LOW);
  // both compare units checked on every timer tick except the first after a counter write
  assign hit_a = tick && !block_q && (cnt_q == ocra_q);
  assign hit_b = tick && !block_q && (cnt_q == ocrb_q);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_b_d = ctrl_b_q;
    temp_d = temp_q;
    cnt_d = cnt_q;
    ocra_d = ocra_q;
    ocrb_d = ocrb_q;
    icr_d = icr_q;
    rdata_d = rdata_q;
    block_d = block_q;
    dir_d = dir_q;
    cap_prev_d = cap_level;
    match_a_d = hit_a;
    match_b_d = hit_b;
    flags_d = flags_q;

    // Counting sequence
    if (tick) begin
      block_d = 1'b0;
      if (dual_slope(wave_mode_field)) begin
        unique case (dir_q)
          TMR_DIR_UP: begin
            if (cnt_q >= top) begin
              dir_d = TMR_DIR_DOWN;
              cnt_d = (cnt_q == 16'h0000) ? cnt_q : cnt_q - 16'h0001;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
          TMR_DIR_DOWN: begin
            if (cnt_q == 16'h0000) begin
              dir_d = TMR_DIR_UP;
              cnt_d = (top == 16'h0000) ? cnt_q : 16'h0001;
            end else begin
              cnt_d = cnt_q - 16'h0001;
            end
          end
        endcase
      end else begin
        dir_d = TMR_DIR_UP;
        cnt_d = (cnt_q >= top) ? 16'h0000 : cnt_q + 16'h0001;
      end
    end

    // Capture event
    if (cap_active && cap_edge) begin
      icr_d = cnt_q;
    end

    // Flag clears first so that a same-cycle set wins
    if (flag_vector_ack.capture || flag_write_clear.capture) begin
      flags_d.capture = 1'b0;
    end
    if (flag_vector_ack.compare_a || flag_write_clear.compare_a) begin
      flags_d.compare_a = 1'b0;
    end
    if (flag_vector_ack.compare_b || flag_write_clear.compare_b) begin
      flags_d.compare_b = 1'b0;
    end
    if (cap_active && cap_edge) begin
      flags_d.capture = 1'b1;
    end
    if (hit_a) begin
      flags_d.compare_a = 1'b1;
    end
    if (hit_b) begin
      flags_d.compare_b = 1'b1;
    end

    // CPU writes; a counter write overrides the tick
    if (io_req.wr) begin
      unique case (io_req.addr)
        OFS_COMPARE_A_HIGH, OFS_COMPARE_B_HIGH, OFS_COUNTER_HIGH: begin
          temp_d = io_req.wdata;
        end
        OFS_COMPARE_A_LOW: begin
          ocra_d = {temp_q, io_req.wdata};
        end
        OFS_COMPARE_B_LOW: begin
          ocrb_d = {temp_q, io_req.wdata};
        end
        OFS_COUNTER_LOW: begin
          cnt_d = {temp_q, io_req.wdata};
          block_d = 1'b1;
        end
        OFS_TIMER_CONTROL_B: begin
          ctrl_b_d = io_req.wdata & CTRL_B_RW_MASK;
        end
        default: begin
        end
      endcase
    end

    // CPU reads, answered one cycle later
    if (io_req.rd) begin
      unique case (io_req.addr)
        OFS_COMPARE_A_LOW: rdata_d = ocra_q[7:0];
        OFS_COMPARE_A_HIGH: rdata_d = ocra_q[15:8];
        OFS_COMPARE_B_LOW: rdata_d = ocrb_q[7:0];
        OFS_COMPARE_B_HIGH: rdata_d = ocrb_q[15:8];
        OFS_COUNTER_LOW: begin
          rdata_d = cnt_q[7:0];
          temp_d = cnt_q[15:8];
        end
        OFS_COUNTER_HIGH: rdata_d = temp_q;
        OFS_TIMER_CONTROL_B: rdata_d = ctrl_b_q;
        default: rdata_d = RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_b_q <= RST_CTRL_B;
      temp_q <= RST_BYTE;
      cnt_q <= RST_WORD;
      ocra_q <= RST_WORD;
      ocrb_q <= RST_WORD;
      icr_q <= RST_WORD;
      rdata_q <= RST_BYTE;
      block_q <= 1'b0;
      dir_q <= TMR_DIR_UP;
      cap_prev_q <= 1'b0;
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
      flags_q <= '0;
    end else begin
      ctrl_b_q <= ctrl_b_d;
      temp_q <= temp_d;
      cnt_q <= cnt_d;
      ocra_q <= ocra_d;
      ocrb_q <= ocrb_d;
      icr_q <= icr_d;
      rdata_q <= rdata_d;
      block_q <= block_d;
      dir_q <= dir_d;
      cap_prev_q <= cap_prev_d;
      match_a_q <= match_a_d;
      match_b_q <= match_b_d;
      flags_q <= flags_d;
    end
  end

  assign io_rdata = rdata_q;
  assign flags = flags_q;
  assign capture_register = icr_q;
  assign counter_value = cnt_q;
  assign compare_a_match = match_a_q;
  assign compare_b_match = match_b_q;

endmodule // tmr_top
`default_nettype wire
